// ### shared/hdc_pkg.sv
// Shared constants and carrier types of the field-sensor conditioning chain.
package hdc_pkg;

    // Word indices of the programming command space.
    localparam logic [3:0] IDX_CONFIG      = 4'h0;
    localparam logic [3:0] IDX_LIN_TC      = 4'h1;
    localparam logic [3:0] IDX_QUAD_TC     = 4'h2;
    localparam logic [3:0] IDX_TC_GROUP    = 4'h3;
    localparam logic [3:0] IDX_GAIN        = 4'h4;
    localparam logic [3:0] IDX_QUIESCENT   = 4'h5;
    localparam logic [3:0] IDX_CLAMP_LOW   = 4'h6;
    localparam logic [3:0] IDX_CLAMP_HIGH  = 4'h7;
    localparam logic [3:0] IDX_USER0       = 4'h8;
    localparam logic [3:0] IDX_USER3       = 4'hb;
    localparam logic [3:0] IDX_FREEZE      = 4'hc;
    localparam logic [3:0] IDX_RAW_READ    = 4'hd;
    localparam logic [3:0] IDX_PROC_READ   = 4'he;
    localparam int         NV_WORDS        = 13;
    localparam int         WORD_W          = 16;

    // Stored-word masks; reserved config bits 8 and 0 are never kept.
    localparam logic [15:0] MASK_CONFIG    = 16'h02fe;
    localparam logic [15:0] MASK_LIN_TC    = 16'h001f;
    localparam logic [15:0] MASK_QUAD_TC   = 16'h0007;
    localparam logic [15:0] MASK_TC_GROUP  = 16'h0003;
    localparam logic [15:0] MASK_GAIN      = 16'h3fff;
    localparam logic [15:0] MASK_QUIESCENT = 16'h07ff;
    localparam logic [15:0] MASK_CLAMP_LOW = 16'h00ff;
    localparam logic [15:0] MASK_CLAMP_HI  = 16'h01ff;
    localparam logic [15:0] MASK_USER      = 16'h1fff;
    localparam logic [15:0] MASK_FREEZE    = 16'h0001;

    // Config field positions.
    localparam int CFG_SPAN_HI   = 9;
    localparam int CFG_FMT_LSB   = 5;
    localparam int CFG_CORNER_LSB = 3;
    localparam int CFG_SPAN_LSB  = 1;

    localparam logic [2:0] FMT_ANALOG = 3'h0;

    // Filter corner codes and their shift of the first-order filter.
    localparam logic [1:0] CORNER_80HZ  = 2'h0;
    localparam logic [1:0] CORNER_500HZ = 2'h2;
    localparam logic [1:0] CORNER_1KHZ  = 2'h3;
    localparam logic [1:0] CORNER_2KHZ  = 2'h1;
    localparam logic [3:0] SHIFT_80HZ   = 4'h8;
    localparam logic [3:0] SHIFT_500HZ  = 4'h5;
    localparam logic [3:0] SHIFT_1KHZ   = 4'h4;
    localparam logic [3:0] SHIFT_2KHZ   = 4'h3;

    // Span codes as {bit9, bits2:1}.
    localparam logic [2:0] SPAN_30MT  = 3'h0;
    localparam logic [2:0] SPAN_60MT  = 3'h1;
    localparam logic [2:0] SPAN_80MT  = 3'h2;
    localparam logic [2:0] SPAN_100MT = 3'h3;
    localparam logic [2:0] SPAN_150MT = 3'h7;

    // Temperature coefficient groups and their linear base slopes.
    localparam logic [1:0] TCG_STEEP_NEG = 2'h0;
    localparam logic [1:0] TCG_NEG       = 2'h2;
    localparam logic [1:0] TCG_FLAT      = 2'h1;
    localparam logic [1:0] TCG_POS       = 2'h3;
    localparam logic signed [7:0] TCB_STEEP_NEG = -8'sd48;
    localparam logic signed [7:0] TCB_NEG       = -8'sd24;
    localparam logic signed [7:0] TCB_FLAT      = 8'sd0;
    localparam logic signed [7:0] TCB_POS       = 8'sd16;
    localparam logic [5:0] LIN_TC_CENTER  = 6'h0f;
    localparam logic [4:0] QUAD_TC_CENTER = 5'h01;

    // Fixed-point layout of the arithmetic.
    localparam int GAIN_FRAC = 11;
    localparam int QUI_SHIFT = 4;
    localparam int CLAMP_SHIFT = 5;
    localparam logic [13:0] PROC_MAX = 14'h3fff;
    localparam logic signed [21:0] FULL_SUPPLY = 22'sh004000;

    typedef struct packed {
        logic        write;
        logic        store;
        logic [3:0]  addr;
        logic [15:0] data;
    } hdc_cmd_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } hdc_reply_t;

    typedef enum logic [1:0] {
        ST_LOAD,
        ST_IDLE,
        ST_STORE
    } hdc_state_t;

endpackage

// ### logic/hdc_nv_store.sv
// Non-volatile word array holding the programmed configuration.
`timescale 1ns/1ns
`default_nettype none

module hdc_nv_store #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 13,
    parameter int AW    = 4
) (
    input  wire logic             clock,
    input  wire logic             wrEn,
    input  wire logic [AW-1:0]    wrAddr,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic [AW-1:0]    rdAddr,
    output logic      [WIDTH-1:0] rdData
);

    // Contents survive the logic reset, as the cells they stand for would.
    logic [WIDTH-1:0] cells [0:DEPTH-1] = '{default: '0};

    always_ff @(posedge clock) begin
        if (wrEn && (int'(wrAddr) < DEPTH)) begin
            cells[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clock) begin
        if (int'(rdAddr) < DEPTH) begin
            rdData <= cells[rdAddr];
        end else begin
            rdData <= '0;
        end
    end

endmodule // hdc_nv_store

`default_nettype wire

// ### logic/hdc_chain.sv
// Field conditioning chain with its programmable configuration words.
//
// Function
// - Each converter sample is low-pass filtered, then configuration applied.
// - Filtered field times gain plus quiescent, then clamped to the window.
// - Processed value spans codes 0 to 16383.
// - Config word is 10 bits: span 9 and 2:1, format 7:5, corner 4:3.
// - Span codes 000,001,010,011,111 give 30,60,80,100,150 mT.
// - Corner codes 00,10,11,01 give 80 Hz, 500 Hz, 1 kHz, 2 kHz.
// - Format 000 selects the 12-bit ratiometric analog output.
// - Coefficient group codes 0,2,1,3 go from steep negative to positive.
// - Linear (5 bits) and quadratic (3 bits) coefficients scale the gain.
// - Gain is a signed multiplier from -4 to 4 in fine steps.
// - Quiescent level is the signed adder operand, output at zero field.
// - Negative quiescent level caps the output at quiescent plus full supply.
// - Lower limit programmable from zero to half supply.
// - Upper limit programmable from zero to full supply.
// - Four user words of 13 bits; words 1 to 3 carry tracking data.
// - Once frozen, registers stay fixed and all commands are ignored.
// - Freeze takes effect only after the next power cycle.
// - Raw converter result is readable for modulation checks.
// - Processed result is readable.
// - Processed readback is 14 bits with reversed bit order.
// - Frozen device refuses reads and the flag cannot be cleared.
// - During a command exchange the output pin leaves analog drive.
`timescale 1ns/1ns
`default_nettype none

module hdc_chain #(
    parameter int SAMPLE_W = 16,
    parameter int DAC_W    = 12
) (
    input  wire logic                       clock,
    input  wire logic                       reset_n,
    input  wire logic                       adcValid,
    input  wire logic signed [SAMPLE_W-1:0] adcSample,
    input  wire logic signed [7:0]          tempDelta,
    input  wire logic                       cmdValid,
    input  wire hdc_pkg::hdc_cmd_t          cmd,
    output logic                            cmdReady,
    output hdc_pkg::hdc_reply_t             reply,
    output logic                            outDigital,
    output logic             [DAC_W-1:0]    dacCode,
    output logic                            dacEnable,
    output logic                            frozen
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release.

    logic [1:0] resetSync;
    logic       rstN;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            resetSync <= 2'b00;
        end else begin
            resetSync <= {resetSync[0], 1'b1};
        end
    end
    assign rstN = resetSync[1];

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    function automatic logic [15:0] wordMask(input logic [3:0] idx);
        case (idx)
            hdc_pkg::IDX_CONFIG:     wordMask = hdc_pkg::MASK_CONFIG;
            hdc_pkg::IDX_LIN_TC:     wordMask = hdc_pkg::MASK_LIN_TC;
            hdc_pkg::IDX_QUAD_TC:    wordMask = hdc_pkg::MASK_QUAD_TC;
            hdc_pkg::IDX_TC_GROUP:   wordMask = hdc_pkg::MASK_TC_GROUP;
            hdc_pkg::IDX_GAIN:       wordMask = hdc_pkg::MASK_GAIN;
            hdc_pkg::IDX_QUIESCENT:  wordMask = hdc_pkg::MASK_QUIESCENT;
            hdc_pkg::IDX_CLAMP_LOW:  wordMask = hdc_pkg::MASK_CLAMP_LOW;
            hdc_pkg::IDX_CLAMP_HIGH: wordMask = hdc_pkg::MASK_CLAMP_HI;
            hdc_pkg::IDX_FREEZE:     wordMask = hdc_pkg::MASK_FREEZE;
            default: begin
                if (idx >= hdc_pkg::IDX_USER0 && idx <= hdc_pkg::IDX_USER3)
                    wordMask = hdc_pkg::MASK_USER;
                else
                    wordMask = 16'h0000;
            end
        endcase
    endfunction

    function automatic logic [13:0] reverse14(input logic [13:0] v);
        logic [13:0] r;
        r = '0;
        for (int i = 0; i < 14; i++) begin
            r[i] = v[13-i];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Working copy of the configuration words.

    hdc_pkg::hdc_state_t state;
    hdc_pkg::hdc_state_t next_state;
    logic [15:0] shadow [0:hdc_pkg::NV_WORDS-1];
    logic [3:0]  walkIdx;
    logic        loadPending;
    logic [3:0]  loadIdx;
    logic [15:0] nvReadData;
    logic        walkLast;

    assign walkLast = (walkIdx == 4'(hdc_pkg::NV_WORDS - 1));

    wire logic        cmdTake   = cmdValid && cmdReady;
    wire logic        cmdWrite  = cmdTake && cmd.write && !cmd.store;
    wire logic        cmdStore  = cmdTake && cmd.store;
    wire logic        nvWrite   = (state == hdc_pkg::ST_STORE);
    wire logic [15:0] wrMasked  = cmd.data & wordMask(cmd.addr);

    // Frozen devices accept nothing at all, reads included.
    assign cmdReady = (state == hdc_pkg::ST_IDLE) && !frozen;

    always_comb begin
        next_state = state;
        case (state)
            hdc_pkg::ST_LOAD: begin
                if (loadPending && loadIdx == 4'(hdc_pkg::NV_WORDS - 1))
                    next_state = hdc_pkg::ST_IDLE;
            end
            hdc_pkg::ST_IDLE: begin
                if (cmdStore)
                    next_state = hdc_pkg::ST_STORE;
            end
            hdc_pkg::ST_STORE: begin
                if (walkLast)
                    next_state = hdc_pkg::ST_IDLE;
            end
            default: next_state = hdc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            state       <= hdc_pkg::ST_LOAD;
            walkIdx     <= 4'h0;
            loadPending <= 1'b0;
            loadIdx     <= 4'h0;
        end else begin
            state       <= next_state;
            loadPending <= (next_state == hdc_pkg::ST_LOAD);
            loadIdx     <= walkIdx;
            if (next_state != state || walkLast)
                walkIdx <= 4'h0;
            else if (state != hdc_pkg::ST_IDLE)
                walkIdx <= walkIdx + 4'h1;
        end
    end

    // The stored freeze bit is only sampled while loading after power-up,
    // so a freshly written flag waits for the next power cycle.
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            frozen <= 1'b0;
        end else if (loadPending && loadIdx == hdc_pkg::IDX_FREEZE) begin
            frozen <= nvReadData[0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < hdc_pkg::NV_WORDS; gi++) begin : g_shadow
            always_ff @(posedge clock or negedge rstN) begin
                if (!rstN) begin
                    shadow[gi] <= 16'h0000;
                end else if (loadPending && loadIdx == 4'(gi)) begin
                    shadow[gi] <= nvReadData & wordMask(4'(gi));
                end else if (cmdWrite && cmd.addr == 4'(gi)) begin
                    // Freeze is set-only; every word is masked.
                    if (4'(gi) == hdc_pkg::IDX_FREEZE)
                        shadow[gi] <= shadow[gi] | wrMasked;
                    else
                        shadow[gi] <= wrMasked;
                end
            end
        end
    endgenerate

    // One store command commits every word in sequence.
    hdc_nv_store #(
        .WIDTH (hdc_pkg::WORD_W),
        .DEPTH (hdc_pkg::NV_WORDS),
        .AW    (4)
    ) u_nv (
        .clock  (clock),
        .wrEn   (nvWrite),
        .wrAddr (walkIdx),
        .wrData (shadow[walkIdx]),
        .rdAddr (walkIdx),
        .rdData (nvReadData)
    );

    ////////////////////////////////////////////////////////////////////////
    // Configuration fields.

    wire logic [15:0] cfgWord   = shadow[hdc_pkg::IDX_CONFIG];
    wire logic [2:0]  spanSel   = {cfgWord[hdc_pkg::CFG_SPAN_HI],
                                   cfgWord[hdc_pkg::CFG_SPAN_LSB +: 2]};
    wire logic [2:0]  formatSel = cfgWord[hdc_pkg::CFG_FMT_LSB +: 3];
    wire logic [1:0]  cornerSel = cfgWord[hdc_pkg::CFG_CORNER_LSB +: 2];
    wire logic [4:0]  linTc     = shadow[hdc_pkg::IDX_LIN_TC][4:0];
    wire logic [2:0]  quadTc    = shadow[hdc_pkg::IDX_QUAD_TC][2:0];
    wire logic [1:0]  tcGroup   = shadow[hdc_pkg::IDX_TC_GROUP][1:0];
    wire logic signed [13:0] gain      = shadow[hdc_pkg::IDX_GAIN][13:0];
    wire logic signed [10:0] quiescent = shadow[hdc_pkg::IDX_QUIESCENT][10:0];
    wire logic [7:0]  clampLow  = shadow[hdc_pkg::IDX_CLAMP_LOW][7:0];
    wire logic [8:0]  clampHigh = shadow[hdc_pkg::IDX_CLAMP_HIGH][8:0];

    // Corner select picks the filter's settling shift.
    wire logic [3:0] filterShift =
        (cornerSel == hdc_pkg::CORNER_80HZ)  ? hdc_pkg::SHIFT_80HZ  :
        (cornerSel == hdc_pkg::CORNER_500HZ) ? hdc_pkg::SHIFT_500HZ :
        (cornerSel == hdc_pkg::CORNER_1KHZ)  ? hdc_pkg::SHIFT_1KHZ  :
                                               hdc_pkg::SHIFT_2KHZ;

    // Wider spans compress the field code; unlisted codes act as 30 mT.
    wire logic [1:0] spanShift =
        (spanSel == hdc_pkg::SPAN_60MT ||
         spanSel == hdc_pkg::SPAN_80MT) ? 2'd1 :
        (spanSel == hdc_pkg::SPAN_100MT) ? 2'd2 :
        (spanSel == hdc_pkg::SPAN_150MT) ? 2'd3 : 2'd0;

    wire logic signed [7:0] tcBase =
        (tcGroup == hdc_pkg::TCG_STEEP_NEG) ? hdc_pkg::TCB_STEEP_NEG :
        (tcGroup == hdc_pkg::TCG_NEG)       ? hdc_pkg::TCB_NEG       :
        (tcGroup == hdc_pkg::TCG_FLAT)      ? hdc_pkg::TCB_FLAT      :
                                              hdc_pkg::TCB_POS;

    ////////////////////////////////////////////////////////////////////////
    // Signal path.

    logic signed [23:0] filterAcc;
    logic signed [15:0] rawSample;
    logic               stageValid;

    wire logic signed [24:0] filterDiff =
        25'($signed({adcSample, 8'h00})) - 25'(filterAcc);
    wire logic signed [24:0] filterStep = filterDiff >>> filterShift;

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            filterAcc  <= 24'sh000000;
            rawSample  <= 16'sh0000;
            stageValid <= 1'b0;
        end else begin
            stageValid <= adcValid;
            if (adcValid) begin
                rawSample <= adcSample;
                filterAcc <= 24'(filterAcc + filterStep);
            end
        end
    end

    wire logic signed [15:0] fieldNorm = $signed(filterAcc[23:8]) >>> spanShift;

    // Gain drifts with temperature by linear and quadratic terms.
    wire logic signed [7:0] linEff =
        8'(tcBase + $signed({3'b000, linTc}) - $signed({2'b00,
           hdc_pkg::LIN_TC_CENTER}));
    wire logic signed [4:0] quadEff =
        5'($signed({2'b00, quadTc}) - $signed(hdc_pkg::QUAD_TC_CENTER));
    wire logic signed [15:0] tSquare = tempDelta * tempDelta;
    wire logic signed [20:0] tQuad   = quadEff * tSquare;
    wire logic signed [20:0] tcCorr  =
        21'(linEff * tempDelta) + (tQuad >>> 4);
    wire logic signed [34:0] gainDrift = gain * tcCorr;
    wire logic signed [15:0] gainEff   =
        16'(gain + (gainDrift >>> 14));

    wire logic signed [31:0] product = fieldNorm * gainEff;
    wire logic signed [21:0] sum =
        22'(product >>> hdc_pkg::GAIN_FRAC) +
        22'(quiescent <<< hdc_pkg::QUI_SHIFT);

    wire logic signed [21:0] qLimit =
        22'(quiescent <<< hdc_pkg::QUI_SHIFT) + hdc_pkg::FULL_SUPPLY;
    wire logic signed [21:0] topCode = $signed({8'h00, hdc_pkg::PROC_MAX});
    wire logic signed [21:0] hiWin =
        $signed({8'h00, 5'h00, clampHigh}) <<< hdc_pkg::CLAMP_SHIFT;
    wire logic signed [21:0] loWin =
        $signed({8'h00, 6'h00, clampLow}) <<< hdc_pkg::CLAMP_SHIFT;
    wire logic signed [21:0] ceilA =
        (quiescent < 0 && qLimit < topCode) ? qLimit : topCode;
    wire logic signed [21:0] ceilB = (hiWin < ceilA) ? hiWin : ceilA;
    // Upper limit is applied last, so a crossed window settles on it.
    wire logic signed [21:0] lowSided = (sum < loWin) ? loWin : sum;
    wire logic signed [21:0] limited  = (lowSided > ceilB) ? ceilB : lowSided;
    wire logic [13:0] procNext =
        (limited < 0) ? 14'h0000 : limited[13:0];

    logic [13:0] procValue;

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            procValue <= 14'h0000;
            dacCode   <= '0;
        end else if (stageValid) begin
            procValue <= procNext;
            dacCode   <= procNext[13 -: DAC_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command replies and pin ownership.

    wire logic [15:0] readWord =
        (cmd.addr == hdc_pkg::IDX_RAW_READ)  ? 16'(rawSample) :
        (cmd.addr == hdc_pkg::IDX_PROC_READ) ?
            {2'b00, reverse14(procValue)} :
        (int'(cmd.addr) < hdc_pkg::NV_WORDS) ? shadow[cmd.addr] : 16'h0000;

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            reply      <= '0;
            outDigital <= 1'b0;
        end else begin
            reply.valid <= cmdTake;
            if (cmdTake)
                reply.data <= (cmd.write || cmd.store) ? 16'h0000 : readWord;
            // Pin leaves analog drive from take to end of store or reply.
            outDigital <= cmdTake || next_state == hdc_pkg::ST_STORE;
        end
    end

    // Analog drive only in format 000 and outside any exchange.
    assign dacEnable = (formatSel == hdc_pkg::FMT_ANALOG) && !outDigital &&
                       (state != hdc_pkg::ST_LOAD);

endmodule // hdc_chain

`default_nettype wire

// ### sim/hdc_chain_asserts.sv
// Port-level assertions for the conditioning chain.
`timescale 1ns/1ns
`default_nettype none
module hdc_chain_asserts #(
    parameter int DAC_W = 12
) (
    input wire logic                clock,
    input wire logic                reset_n,
    input wire logic                adcValid,
    input wire logic                cmdValid,
    input wire hdc_pkg::hdc_cmd_t   cmd,
    input wire logic                cmdReady,
    input wire hdc_pkg::hdc_reply_t reply,
    input wire logic                outDigital,
    input wire logic [DAC_W-1:0]    dacCode,
    input wire logic                dacEnable,
    input wire logic                frozen
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    wire logic take  = cmdValid && cmdReady;
    wire logic rdAny = take && !cmd.write && !cmd.store;
    wire logic rdCfg = rdAny && cmd.addr == hdc_pkg::IDX_CONFIG;
    wire logic rdUsr = rdAny && cmd.addr >= hdc_pkg::IDX_USER0
                       && cmd.addr <= hdc_pkg::IDX_USER3;
    property p_answer; take |=> reply.valid; endproperty
    a_answer: assert property (p_answer)
        else $error("no reply one cycle after a taken command");
    property p_noSpur; reply.valid |-> $past(take); endproperty
    a_noSpur: assert property (p_noSpur)
        else $error("reply without a taken command");
    property p_digital; take |=> outDigital; endproperty
    a_digital: assert property (p_digital)
        else $error("output pin stayed analog during exchange");
    property p_analogOff; outDigital |-> !dacEnable; endproperty
    a_analogOff: assert property (p_analogOff)
        else $error("analog drive during digital exchange");
    property p_refuse; frozen |-> !cmdReady && !reply.valid; endproperty
    a_refuse: assert property (p_refuse)
        else $error("frozen device accepted or answered a command");
    property p_keep; frozen |=> frozen; endproperty
    a_keep: assert property (p_keep)
        else $error("freeze flag cleared");
    property p_reserved;
        $past(rdCfg) |-> reply.data[8] == 1'b0 && reply.data[0] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved config bits read nonzero");
    property p_userW; $past(rdUsr) |-> reply.data[15:13] == 3'h0; endproperty
    a_userW: assert property (p_userW)
        else $error("user word wider than 13 bits");
    property p_storeBlk; take && cmd.store |=> !cmdReady [*8]; endproperty
    a_storeBlk: assert property (p_storeBlk)
        else $error("command accepted during store");
    property p_hold; !$past(adcValid, 2) |-> $stable(dacCode); endproperty
    a_hold: assert property (p_hold)
        else $error("output code changed without a sample");
endmodule // hdc_chain_asserts
bind hdc_chain hdc_chain_asserts #(.DAC_W(DAC_W)) uChk (
    .clock(clock), .reset_n(reset_n), .adcValid(adcValid),
    .cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady), .reply(reply),
    .outDigital(outDigital), .dacCode(dacCode), .dacEnable(dacEnable),
    .frozen(frozen)
);
`default_nettype wire

// ### sim/hdc_programmer.sv
// Behavioural programmer issuing decoded supply-modulated commands.
`timescale 1ns/1ns
`default_nettype none
module hdc_programmer (
    input  wire logic                clock,
    input  wire logic                cmdReady,
    input  wire hdc_pkg::hdc_reply_t reply,
    output logic                     cmdValid,
    output hdc_pkg::hdc_cmd_t        cmd
);
    initial begin
        cmdValid = 1'b0;
        cmd = '0;
    end
    // Word order and one store per update are kept by the caller.
    task automatic xfer(input logic wr, input logic st, input logic [3:0] a,
                        input logic [15:0] d, output logic [15:0] q);
        logic ok;
        int   n;
        n = 0;
        repeat ($urandom_range(2)) @(posedge clock);
        @(posedge clock);
        cmdValid <= 1'b1;
        cmd <= '{write: wr, store: st, addr: a, data: d};
        do begin
            @(negedge clock);
            ok = cmdReady;
            n++;
            @(posedge clock);
        end while (ok !== 1'b1 && n < 60);
        cmdValid <= 1'b0;
        // Released lines show the inverse so a stale word is never reused.
        cmd <= ~cmd;
        @(negedge clock);
        q = reply.data;
    endtask
endmodule // hdc_programmer
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the conditioning chain.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic                clock     = 1'b0;
    logic                reset_n   = 1'b0;
    logic                adcValid  = 1'b0;
    logic signed [15:0]  adcSample = 16'sh0000;
    logic signed [7:0]   tempDelta = 8'sh00;
    logic                cmdValid;
    hdc_pkg::hdc_cmd_t   cmd;
    hdc_pkg::hdc_reply_t reply;
    logic                cmdReady;
    logic                outDigital;
    logic [11:0]         dacCode;
    logic                dacEnable;
    logic                frozen;
    logic [15:0]         q;
    logic [15:0]         model [12];
    int                  miscompares = 0;
    int                  tests_run   = 0;
    always #5 clock = ~clock;
    hdc_chain dut (.clock(clock), .reset_n(reset_n), .adcValid(adcValid),
        .adcSample(adcSample), .tempDelta(tempDelta), .cmdValid(cmdValid),
        .cmd(cmd), .cmdReady(cmdReady), .reply(reply),
        .outDigital(outDigital), .dacCode(dacCode), .dacEnable(dacEnable),
        .frozen(frozen));
    hdc_programmer prog (.clock(clock), .cmdReady(cmdReady), .reply(reply),
        .cmdValid(cmdValid), .cmd(cmd));
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        prog.xfer(1'b1, 1'b0, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a);
        prog.xfer(1'b0, 1'b0, a, 16'h0000, q);
    endtask
    task automatic power_cycle;
        int n;
        n = 0;
        // A store in flight needs its 13 cycles before power drops.
        repeat (14) @(posedge clock);
        reset_n <= 1'b0;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        do begin
            @(negedge clock);
            n++;
        end while (cmdReady !== 1'b1 && n < 40);
    endtask
    function automatic logic [15:0] rev14(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 14; i++) r[i] = v[13-i];
        return r;
    endfunction
    initial begin
        logic [15:0] d;
        logic [15:0] masks [12];
        logic [2:0]  spans [5];
        int          cs [5][3];
        int          p;
        void'($urandom(32'hc903));
        masks = '{hdc_pkg::MASK_CONFIG, hdc_pkg::MASK_LIN_TC,
            hdc_pkg::MASK_QUAD_TC, hdc_pkg::MASK_TC_GROUP, hdc_pkg::MASK_GAIN,
            hdc_pkg::MASK_QUIESCENT, hdc_pkg::MASK_CLAMP_LOW,
            hdc_pkg::MASK_CLAMP_HI, hdc_pkg::MASK_USER, hdc_pkg::MASK_USER,
            hdc_pkg::MASK_USER, hdc_pkg::MASK_USER};
        spans = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
        cs = '{'{256, 0, 511}, '{256, 255, 511}, '{256, 0, 64},
               '{-256, 0, 511}, '{1023, 0, 511}};
        power_cycle();
        check("frozen at start", {15'h0, frozen}, 16'h0000);
        // Random words, reserved config bits included, come back masked.
        for (int i = 0; i < 12; i++) begin
            d = 16'($urandom());
            model[i] = d & masks[i];
            wr(4'(i), d);
        end
        for (int i = 0; i < 12; i++) begin
            rd(4'(i));
            check("word", q, model[i]);
        end
        rd(4'hf);
        check("unmapped", q, 16'h0000);
        $display("test registers done");
        prog.xfer(1'b0, 1'b1, 4'h0, 16'h0000, q);
        power_cycle();
        for (int i = 0; i < 12; i++) begin
            rd(4'(i));
            check("stored word", q, model[i]);
        end
        $display("test store done");
        wr(hdc_pkg::IDX_GAIN, 16'h0000);
        for (int k = 0; k < 5; k++) begin
            // Reserved bits written as zero.
            wr(hdc_pkg::IDX_CONFIG, {6'h00, spans[k][2], 4'h0, 2'(k),
                spans[k][1:0], 1'b0});
            wr(hdc_pkg::IDX_TC_GROUP, 16'(k % 4));
            wr(hdc_pkg::IDX_QUIESCENT, 16'(cs[k][0]));
            wr(hdc_pkg::IDX_CLAMP_LOW, 16'(cs[k][1]));
            wr(hdc_pkg::IDX_CLAMP_HIGH, 16'(cs[k][2]));
            d = 16'($urandom());
            @(posedge clock);
            adcValid  <= 1'b1;
            adcSample <= d;
            @(posedge clock);
            adcValid <= 1'b0;
            repeat (2) @(posedge clock);
            p = cs[k][0] * 16;
            p = (p < cs[k][1] * 32) ? cs[k][1] * 32 : p;
            p = (p > cs[k][2] * 32) ? cs[k][2] * 32 : p;
            p = (p < 0) ? 0 : p;
            rd(hdc_pkg::IDX_PROC_READ);
            check("processed", rev14(q), 16'(p));
            check("dac code", {4'h0, dacCode}, 16'(p >> 2));
            rd(hdc_pkg::IDX_RAW_READ);
            check("raw", q, d);
            @(negedge clock);
            check("analog drive", {15'h0, dacEnable}, 16'h0001);
        end
        $display("test processing done");
        wr(hdc_pkg::IDX_FREEZE, 16'h0001);
        prog.xfer(1'b0, 1'b1, 4'h0, 16'h0000, q);
        check("frozen early", {15'h0, frozen}, 16'h0000);
        power_cycle();
        check("frozen", {15'h0, frozen}, 16'h0001);
        check("ready", {15'h0, cmdReady}, 16'h0000);
        power_cycle();
        check("frozen again", {15'h0, frozen}, 16'h0001);
        $display("test freeze done");
        end_of_test();
    end
    initial begin
        #400000;
        miscompares++;
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
